// ==== logic/fpp_pkg.sv ====
/*
 Package for the five-pin port: register indices, bit masks, reset values,
 and the carrier structs shared by the port top and its pin synchroniser.
 Assumes a single 100 MHz clock domain and a plain register port.
*/
`default_nettype none
package fpp_pkg;
    localparam logic [3:0] PIN_LEVEL_IDX = 4'h0;
    localparam logic [3:0] OUTPUT_LATCH_IDX = 4'h1;
    localparam logic [3:0] DIRECTION_IDX = 4'h2;
    localparam logic [3:0] PORT_CONFIG_IDX = 4'h3;
    localparam logic [3:0] ALT_CTRL_IDX = 4'h4;
    localparam logic [7:0] IMPL_MASK = 8'h2F;
    localparam logic [7:0] DIRECTION_RST = 8'h2F;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [3:0] PORT_CONFIG_RST = 4'h0;
    localparam logic [3:0] ALT_CTRL_RST = 4'h0;
    localparam int REF_OUT_BIT = 0;
    localparam int CMP2_ROUTE_BIT = 1;
    localparam int SSEL_USE_BIT = 2;
    localparam int CLKOUT_MODE_BIT = 3;
    localparam int REF_PIN = 2;
    localparam int CMP2_PIN = 5;
    localparam logic [1:0] CYCLE_DIV_LAST = 2'h1;
    localparam int SYNC_STAGES = 3;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fpp_req_t;

    typedef struct packed {
        logic [7:0] pinOut;
        logic [7:0] pinOe;
        logic [7:0] rdata;
        logic [7:0] analogSel;
        logic serialSlaveSelectIn;
        logic cycleClockOut;
    } fpp_out_t;

    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] direction;
        logic [3:0] portConfig;
        logic [3:0] altCtrl;
        logic [1:0] divCnt;
        logic cycleClk;
        fpp_out_t out;
    } fpp_state_t;

    typedef struct packed {
        logic [SYNC_STAGES-1:0] stage;
        logic level;
    } fpp_sync_t;
endpackage
`default_nettype wire

// ==== logic/fpp_pin_sync.sv ====
/*
 Three-stage pin synchroniser with an agree filter: the clean level moves
 only when the second and third stages match.
 Assumes the pin is asynchronous to clock.
*/
`timescale 1ns/10ps
`default_nettype none
module fpp_pin_sync (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic pinIn,
    output logic level
);
    fpp_pkg::fpp_sync_t state_r;
    fpp_pkg::fpp_sync_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        state_nxt.stage = {state_r.stage[1:0], pinIn};
        // Stage 0 feeds stage 1 only
        if (state_r.stage[1] == state_r.stage[2]) begin
            state_nxt.level = state_r.stage[2];
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign level = state_r.level;
endmodule
`default_nettype wire

// ==== logic/fpp_port.sv ====
/*
 Five-pin general-purpose port with direction, output latch and pin read,
 plus the alternate-function overrides on bits 2 and 5 and a cycle clock out.
 Assumes comparator, reference and converter logic live elsewhere; their enables are
 held here and only the second comparator hands in its result; pins are resolved outside from out/oe.
*/
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module fpp_port (
    input wire logic clock,
    input wire logic sys_rst,
    input wire fpp_pkg::fpp_req_t req,
    input wire logic [7:0] pinIn,
    input wire logic secondComparatorResult,
    output logic [7:0] rdata,
    output logic [7:0] pinOut,
    output logic [7:0] pinOe,
    output logic [7:0] analogSel,
    output logic serialSlaveSelectIn,
    output logic cycleClockOut
);
    fpp_pkg::fpp_state_t state_r;
    fpp_pkg::fpp_state_t state_nxt;
    logic [7:0] pinLevel;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : gSync
            fpp_pin_sync uSync (
                .clock(clock),
                .sys_rst(sys_rst),
                .pinIn(pinIn[g]),
                .level(pinLevel[g])
            );
        end
    endgenerate

    // Analog map per configuration code; higher codes free more pins
    function automatic logic [7:0] analogMap(input logic [3:0] cfg);
        logic [7:0] m;
        m = 8'h00;
        if (cfg <= 4'hA) begin
            m[5] = 1'b1;
        end
        if (cfg <= 4'hB) begin
            m[3] = 1'b1;
        end
        if (cfg <= 4'hC) begin
            m[2] = 1'b1;
        end
        if (cfg <= 4'hD) begin
            m[1] = 1'b1;
        end
        if (cfg <= 4'hE) begin
            m[0] = 1'b1;
        end
        return m & fpp_pkg::IMPL_MASK;
    endfunction

    always_comb begin
        logic [7:0] ana;
        logic [7:0] oe;
        logic [7:0] dout;
        logic [7:0] din;
        logic refOn;
        ana = 8'h00;
        oe = 8'h00;
        dout = 8'h00;
        din = 8'h00;
        refOn = 1'b0;
        state_nxt = state_r;

        if (req.wr) begin
            unique case (req.addr)
                fpp_pkg::PIN_LEVEL_IDX,
                fpp_pkg::OUTPUT_LATCH_IDX: begin
                    state_nxt.latch = req.wdata & fpp_pkg::IMPL_MASK;
                end
                fpp_pkg::DIRECTION_IDX: begin
                    state_nxt.direction = req.wdata & fpp_pkg::IMPL_MASK;
                end
                fpp_pkg::PORT_CONFIG_IDX: begin
                    state_nxt.portConfig = req.wdata[3:0];
                end
                fpp_pkg::ALT_CTRL_IDX: begin
                    state_nxt.altCtrl = req.wdata[3:0];
                end
                default: begin
                end
            endcase
        end

        ana = analogMap(state_nxt.portConfig);
        refOn = state_nxt.altCtrl[fpp_pkg::REF_OUT_BIT];

        oe = ~state_nxt.direction & fpp_pkg::IMPL_MASK;
        dout = state_nxt.latch;
        if (state_nxt.altCtrl[fpp_pkg::CMP2_ROUTE_BIT]) begin
            dout[fpp_pkg::CMP2_PIN] = secondComparatorResult;
        end
        if (refOn) begin
            oe[fpp_pkg::REF_PIN] = 1'b0;
        end

        // input gated by analog
        // Driven pins read back their own level, so no direction gating
        din = pinLevel & ~ana & fpp_pkg::IMPL_MASK;
        if (refOn) begin
            din[fpp_pkg::REF_PIN] = 1'b0;
        end

        if (state_r.divCnt == fpp_pkg::CYCLE_DIV_LAST) begin
            state_nxt.divCnt = 2'h0;
            state_nxt.cycleClk = ~state_r.cycleClk;
        end else begin
            state_nxt.divCnt = state_r.divCnt + 2'h1;
        end

        state_nxt.out.pinOut = dout & oe;
        state_nxt.out.pinOe = oe;
        state_nxt.out.analogSel = ana;
        state_nxt.out.serialSlaveSelectIn = state_r.altCtrl[fpp_pkg::SSEL_USE_BIT]
            ? (pinLevel[fpp_pkg::CMP2_PIN] | ~state_r.direction[fpp_pkg::CMP2_PIN]) : 1'b1;
        state_nxt.out.cycleClockOut = state_r.altCtrl[fpp_pkg::CLKOUT_MODE_BIT] & state_nxt.cycleClk;

        state_nxt.out.rdata = 8'h00;
        if (req.rd) begin
            unique case (req.addr)
                fpp_pkg::PIN_LEVEL_IDX: begin
                    state_nxt.out.rdata = din;
                end
                fpp_pkg::OUTPUT_LATCH_IDX: begin
                    state_nxt.out.rdata = state_r.latch;
                end
                fpp_pkg::DIRECTION_IDX: begin
                    state_nxt.out.rdata = state_r.direction;
                end
                fpp_pkg::PORT_CONFIG_IDX: begin
                    state_nxt.out.rdata = {4'h0, state_r.portConfig};
                end
                fpp_pkg::ALT_CTRL_IDX: begin
                    state_nxt.out.rdata = {4'h0, state_r.altCtrl};
                end
                default: begin
                    state_nxt.out.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_r.latch <= fpp_pkg::LATCH_RST;
            state_r.direction <= fpp_pkg::DIRECTION_RST;
            state_r.portConfig <= fpp_pkg::PORT_CONFIG_RST;
            state_r.altCtrl <= fpp_pkg::ALT_CTRL_RST;
            state_r.divCnt <= 2'h0;
            state_r.cycleClk <= 1'b0;
            state_r.out.pinOut <= 8'h00;
            state_r.out.pinOe <= 8'h00;
            state_r.out.rdata <= 8'h00;
            state_r.out.analogSel <= fpp_pkg::IMPL_MASK;
            state_r.out.serialSlaveSelectIn <= 1'b1;
            state_r.out.cycleClockOut <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign rdata = state_r.out.rdata;
    assign pinOut = state_r.out.pinOut;
    assign pinOe = state_r.out.pinOe;
    assign analogSel = state_r.out.analogSel;
    assign serialSlaveSelectIn = state_r.out.serialSlaveSelectIn;
    assign cycleClockOut = state_r.out.cycleClockOut;
endmodule
`default_nettype wire

// ==== testbench/fpp_pin_model.sv ====
/*
 Pin-side partner: resolves each pin from the port drive and the outside level.
 Assumes the outside drives every pin that the port leaves undriven.
*/
`timescale 1ns/10ps
`default_nettype none
module fpp_pin_model (
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    input wire logic [7:0] extLevel,
    output logic [7:0] pinIn
);
    assign pinIn = (pinOut & pinOe) | (extLevel & ~pinOe);
endmodule
`default_nettype wire

// ==== testbench/fpp_port_checker.sv ====
/*
 Port checker: timing relations at the port pins and register port.
 Assumes single clock; shadows direction and alt control from writes.
*/
`timescale 1ns/10ps
`default_nettype none
module fpp_port_checker (
    input wire logic clock,
    input wire logic sys_rst,
    input wire fpp_pkg::fpp_req_t req,
    input wire logic [7:0] pinIn,
    input wire logic secondComparatorResult,
    input wire logic [7:0] rdata,
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    input wire logic [7:0] analogSel,
    input wire logic serialSlaveSelectIn,
    input wire logic cycleClockOut
);
    logic [7:0] dir_r;
    logic [3:0] alt_r;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            dir_r <= fpp_pkg::DIRECTION_RST;
            alt_r <= fpp_pkg::ALT_CTRL_RST;
        end else if (req.wr && req.addr == fpp_pkg::DIRECTION_IDX) begin
            dir_r <= req.wdata;
        end else if (req.wr && req.addr == fpp_pkg::ALT_CTRL_IDX) begin
            alt_r <= req.wdata[3:0];
        end
    end
    sequence s_two_high;
        cycleClockOut[*2] ##1 !cycleClockOut;
    endsequence
    a_read_one_cycle: assert property (!$past(req.rd) |-> rdata == 8'h00) else $error("rdata outside read");
    a_unimpl_zero: assert property ((rdata & 8'hD0) == 8'h00 && (pinOe & 8'hD0) == 8'h00) else $error("bits 7 6 4 set");
    a_reset_analog: assert property ($fell(sys_rst) |-> analogSel == 8'h2F && pinOe == 8'h00) else $error("bad reset");
    a_latch_drive: assert property (req.wr && (req.addr == fpp_pkg::OUTPUT_LATCH_IDX
        || req.addr == fpp_pkg::PIN_LEVEL_IDX) && dir_r[1:0] == 2'h0
        |=> pinOe[0] && pinOut[1:0] == $past(req.wdata[1:0])) else $error("latch not driven");
    a_ref_no_drive: assert property (alt_r[0] |-> !pinOe[2]) else $error("bit2 driven with ref out");
    a_cmp_route: assert property (alt_r[1] && $past(alt_r[1]) && !dir_r[5] && !$past(dir_r[5])
        |-> pinOe[5] && pinOut[5] == $past(secondComparatorResult)) else $error("comparator not on bit5");
    a_ssel_idle: assert property (!alt_r[2] && !$past(alt_r[2]) |-> serialSlaveSelectIn) else $error("slave select low");
    a_clk_shape: assert property (@(posedge clock) disable iff (sys_rst || !alt_r[3])
        $rose(cycleClockOut) && $past(alt_r[3], 2) |-> s_two_high) else $error("cycle clock shape");
    a_clk_off: assert property (!alt_r[3] && !$past(alt_r[3]) |=> !cycleClockOut) else $error("cycle clock when off");
    a_cfg_digital: assert property (req.wr && req.addr == fpp_pkg::PORT_CONFIG_IDX && req.wdata[3:0] == 4'hF
        |=> analogSel == 8'h00) else $error("config not digital");
endmodule
bind fpp_port fpp_port_checker CHK (.clock(clock), .sys_rst(sys_rst), .req(req), .pinIn(pinIn),
    .secondComparatorResult(secondComparatorResult), .rdata(rdata), .pinOut(pinOut), .pinOe(pinOe),
    .analogSel(analogSel), .serialSlaveSelectIn(serialSlaveSelectIn), .cycleClockOut(cycleClockOut));
`default_nettype wire

// ==== testbench/fpp_port_test.sv ====
/*
 Self-checking bench for the five-pin port with an integer register model.
 Assumes pin levels settle through the synchroniser within six cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module fpp_port_test;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    fpp_pkg::fpp_req_t req = '0;
    logic [7:0] ext = 8'h00;
    logic cmp = 1'b0;
    logic [7:0] pinIn, rdata, pinOut, pinOe, analogSel, v;
    logic ssel, cko;
    int error_cnt = 0, checked = 0, cyc = 0, lat = 0, dir = 'h2F, cfg = 0, alt = 0, cnt;
    always #5 clock = ~clock;
    // Ceiling well above the few hundred cycles of the run
    always @(posedge clock) begin
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            finish_test();
        end
    end
    fpp_port DUT (.clock(clock), .sys_rst(sys_rst), .req(req), .pinIn(pinIn), .secondComparatorResult(cmp),
        .rdata(rdata), .pinOut(pinOut), .pinOe(pinOe), .analogSel(analogSel), .serialSlaveSelectIn(ssel),
        .cycleClockOut(cko));
    fpp_pin_model PINS (.pinOut(pinOut), .pinOe(pinOe), .extLevel(ext), .pinIn(pinIn));
    function automatic logic [7:0] anaExp();
        return {2'b00, cfg <= 10, 1'b0, cfg <= 11, cfg <= 12, cfg <= 13, cfg <= 14};
    endfunction
    function automatic logic [7:0] oeExp();
        int o;
        o = ~dir & 'h2F;
        if (alt[0]) o &= ~4;
        return o[7:0];
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock) req <= '{a, d, 1'b1, 1'b0};
        @(posedge clock) req.wr <= 1'b0;
        #1;
        case (a)
            0, 1: lat = d & 'h2F;
            2: dir = d & 'h2F;
            3: cfg = d[3:0];
            4: alt = d[3:0];
            default: ;
        endcase
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clock) req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock) req.rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic settle(input logic [7:0] e);
        @(posedge clock) ext <= e;
        repeat (6) @(posedge clock);
    endtask
    task automatic finish_test();
        $display("checked=%0d error_cnt=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hF5B36095));
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        rd(0); chk(v, 8'h00);
        rd(2); chk(v, 8'h2F);
        chk(analogSel, anaExp());
        $display("test reset done");
        // Pins still analog here, so the drive must ignore that
        wr(2, 8'h00); wr(0, 8'($urandom));
        chk(pinOut & pinOe, lat & oeExp());
        rd(1); chk(v, lat[7:0]);
        wr(1, 8'hFF); chk(pinOe, oeExp());
        rd(1); chk(v, 8'h2F);
        $display("test latch done");
        wr(2, 8'hFF);
        for (int c = 0; c < 16; c++) begin
            wr(3, c[7:0]); chk(analogSel, anaExp());
            settle(8'($urandom));
            rd(0); chk(v, ext & 8'h2F & ~anaExp());
        end
        $display("test config done");
        wr(4, 8'h01); wr(2, 8'h00); chk(pinOe, oeExp());
        settle(8'h00);
        rd(0); chk(v, 8'h2B);
        wr(2, 8'h2F); settle(8'hFF);
        rd(0); chk(v, 8'h2B);
        wr(4, 8'h02); wr(2, 8'h00);
        repeat (6) begin
            @(posedge clock) cmp <= 1'($urandom);
            @(posedge clock);
            #1 chk({7'h00, pinOut[5] & pinOe[5]}, {7'h00, cmp});
        end
        wr(4, 8'h04); wr(2, 8'h2F);
        for (int b = 0; b < 2; b++) begin
            settle({2'b00, b[0], 5'h00});
            #1 chk({7'h00, ssel}, {7'h00, b[0]});
        end
        $display("test alternate done");
        // Direction all inputs: clock out must not care
        wr(4, 8'h08);
        repeat (4) @(posedge clock);
        cnt = 0;
        repeat (16) begin
            @(posedge clock);
            #1 if (cko === 1'b1) cnt++;
        end
        chk(cnt[7:0], 8'h08);
        wr(9, 8'hFF); rd(9); chk(v, 8'h00);
        $display("test clock and unmapped done");
        finish_test();
    end
endmodule
`default_nettype wire
